// File: core/asti_interval.sv
`timescale 1ns/100ps
module asti_interval (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire asti_pkg::asti_cpu_req_t cpu_req,
  input  wire logic                   osc_div2_sel,
  input  wire asti_pkg::asti_xfer_t   xfer,
  output logic [7:0]                  cpu_rdata,
  output logic                        hold_sck,
  output logic                        busy_option_disable,
  output logic                        interval_timing_enable
);
  // gap length in main clock ticks for a count value
  function automatic logic [11:0] gap_ticks(input logic [4:0] n);
    gap_ticks = ({7'h00, n} + 12'h001) * asti_pkg::ASTI_GAP_UNIT + asti_pkg::ASTI_GAP_OFS;
  endfunction

  // register address match
  function automatic logic hit(input logic [15:0] a);
    hit = (a == asti_pkg::ASTI_REG_ADDR);
  endfunction

  typedef enum {ASTI_IDLE, ASTI_COUNT, ASTI_ALIGN} asti_state_t;

  logic [7:0]  ctrl_reg;        // interval register
  logic [7:0]  ctrl_next;
  logic [7:0]  rdata_reg;       // read data latch
  logic [7:0]  rdata_next;
  logic        div_reg;         // halved timebase phase
  logic        div_next;
  logic        tick;            // main system clock tick
  asti_state_t state_reg;       // gap sequencer
  asti_state_t state_next;
  logic [11:0] cnt_reg;         // ticks left in gap
  logic [11:0] cnt_next;
  logic [1:0]  sck_reg;         // serial ticks seen in gap
  logic [1:0]  sck_next;
  logic [4:0]  count_field;

  assign interval_timing_enable = ctrl_reg[asti_pkg::ASTI_EN_BIT];
  assign count_field            = ctrl_reg[asti_pkg::ASTI_CNT_LSB +: asti_pkg::ASTI_CNT_W];
  assign cpu_rdata              = rdata_reg;

  // register file next values
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (sys_rst) begin
      ctrl_next  = asti_pkg::ASTI_REG_RESET;
      rdata_next = 8'h00;
    end else begin
      // byte write, reserved bits held at zero
      if (cpu_req.wr_byte && hit(cpu_req.addr)) begin
        ctrl_next = cpu_req.wdata & asti_pkg::ASTI_REG_MASK;
      end else if (cpu_req.wr_bit && hit(cpu_req.addr)) begin
        // bit write, one bit only
        ctrl_next[cpu_req.bit_sel] = cpu_req.bit_val;
        ctrl_next = ctrl_next & asti_pkg::ASTI_REG_MASK;
      end
      // reads return zero off the register
      if (cpu_req.rd) begin
        rdata_next = hit(cpu_req.addr) ? ctrl_reg : 8'h00;
      end
    end
  end

  // register file flops
  always_ff @(posedge clock) begin
    ctrl_reg  <= ctrl_next;
    rdata_reg <= rdata_next;
  end

  // main clock prescale: every cycle or every other
  always_comb begin
    div_next = sys_rst ? 1'b0 : ~div_reg;
    tick     = osc_div2_sel ? div_reg : 1'b1;
  end

  always_ff @(posedge clock) begin
    div_reg <= div_next;
  end

  // gap sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sck_next   = sck_reg;
    if (sys_rst) begin
      state_next = ASTI_IDLE;
      cnt_next   = 12'h000;
      sck_next   = 2'h0;
    end else begin
      case (state_reg)
        // wait for a byte end
        ASTI_IDLE: begin
          if (xfer.byte_done && interval_timing_enable) begin
            state_next = ASTI_COUNT;
            cnt_next   = gap_ticks(count_field);
            sck_next   = 2'h0;
          end
        end
        // count main clock ticks
        ASTI_COUNT: begin
          if (xfer.sck_tick && sck_reg != asti_pkg::ASTI_MIN_SCK) begin
            sck_next = sck_reg + 2'h1;
          end
          if (tick) begin
            if (cnt_reg == 12'h001) begin
              state_next = ASTI_ALIGN;
            end
            cnt_next = cnt_reg - 12'h001;
          end
        end
        // release on a serial tick after two seen
        ASTI_ALIGN: begin
          if (xfer.sck_tick) begin
            if (sck_reg == asti_pkg::ASTI_MIN_SCK) begin
              state_next = ASTI_IDLE;
            end else begin
              sck_next = sck_reg + 2'h1;
            end
          end
        end
        default: begin
          state_next = ASTI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
    cnt_reg   <= cnt_next;
    sck_reg   <= sck_next;
  end

  // hold the serial clock while the gap runs
  assign hold_sck            = (state_reg != ASTI_IDLE);
  // busy input unusable while spacing is timed
  assign busy_option_disable = interval_timing_enable;

  // helper: count-phase ticks and serial ticks (saturating) in a gap
  logic [11:0] chk_ticks;
  logic [2:0]  chk_sck;
  logic [11:0] chk_min;
  always_ff @(posedge clock) begin
    if (sys_rst || state_reg == ASTI_IDLE) begin
      chk_ticks <= 12'h000;
      chk_sck   <= 3'h0;
      chk_min   <= gap_ticks(count_field) - asti_pkg::ASTI_GAP_OFS + asti_pkg::ASTI_GAP_MIN_OF;
    end else begin
      chk_ticks <= chk_ticks + {11'h000, tick && state_reg == ASTI_COUNT};
      chk_sck   <= (chk_sck == 3'h7) ? chk_sck : chk_sck + {2'h0, xfer.sck_tick};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    state_reg == ASTI_IDLE && xfer.byte_done && interval_timing_enable;
  endsequence
  sequence s_gap_end;
    hold_sck ##1 !hold_sck;
  endsequence

  property p_reset_clear;
    @(posedge clock) disable iff (1'b0)
      sys_rst |=> ctrl_reg == asti_pkg::ASTI_REG_RESET && !hold_sck;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not cleared");

  property p_byte_write;
    cpu_req.wr_byte && hit(cpu_req.addr)
      |=> ctrl_reg == ($past(cpu_req.wdata) & asti_pkg::ASTI_REG_MASK);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost");

  property p_bit_write;
    cpu_req.wr_bit && !cpu_req.wr_byte && hit(cpu_req.addr) && cpu_req.bit_sel == 3'h7
      |=> interval_timing_enable == $past(cpu_req.bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write lost");

  property p_no_gap_disabled;
    state_reg == ASTI_IDLE && !interval_timing_enable |=> !hold_sck;
  endproperty
  a_no_gap_disabled: assert property (p_no_gap_disabled) else $error("gap while disabled");

  property p_gap_start;
    s_start |=> hold_sck [*8];
  endproperty
  a_gap_start: assert property (p_gap_start) else $error("gap not started");

  property p_gap_min;
    s_gap_end |-> $past(chk_ticks) >= $past(chk_min);
  endproperty
  a_gap_min: assert property (p_gap_min) else $error("gap too short");

  property p_gap_max_ticks;
    hold_sck |-> chk_ticks <= chk_min + (asti_pkg::ASTI_GAP_MAX_OF - asti_pkg::ASTI_GAP_MIN_OF);
  endproperty
  a_gap_max_ticks: assert property (p_gap_max_ticks) else $error("gap count too long");

  property p_two_sck;
    s_gap_end |-> $past(chk_sck) >= 3'h2;
  endproperty
  a_two_sck: assert property (p_two_sck) else $error("gap under two sck");

  property p_busy_off;
    busy_option_disable == ctrl_reg[asti_pkg::ASTI_EN_BIT];
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy option not disabled");

  property p_read_back;
    cpu_req.rd && hit(cpu_req.addr) |=> cpu_rdata == $past(ctrl_reg);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_halved_tick;
    osc_div2_sel && tick ##1 osc_div2_sel |-> !tick;
  endproperty
  a_halved_tick: assert property (p_halved_tick) else $error("halved tick wrong");
endmodule // asti_interval

// File: core/asti_pkg.sv
// What this block does
// - reset clears the interval register to zero
// - register written by byte or by bit
// - enable low: no timed gap inserted
// - enable high: gap timed from count field
// - gap spans (n+1)*64 plus 28..36 plus sck
// - gap never below two serial clock periods
// - timebase is oscillator or oscillator halved
// - timed spacing disables the busy input option
package asti_pkg;
  // register address and field layout
  localparam logic [15:0] ASTI_REG_ADDR   = 16'hFF6B;
  localparam logic [7:0]  ASTI_REG_RESET  = 8'h00;
  localparam logic [7:0]  ASTI_REG_MASK   = 8'h9F;   // bits 6..5 read as zero
  localparam int          ASTI_EN_BIT     = 7;
  localparam int          ASTI_CNT_LSB    = 0;
  localparam int          ASTI_CNT_W      = 5;
  // gap timing in main clock periods
  localparam logic [11:0] ASTI_GAP_UNIT   = 12'h040; // 2^6 periods per count step
  localparam logic [11:0] ASTI_GAP_MIN_OF = 12'h01C; // 28 periods least offset
  localparam logic [11:0] ASTI_GAP_MAX_OF = 12'h024; // 36 periods longest offset
  localparam logic [11:0] ASTI_GAP_OFS    = 12'h020; // offset actually counted
  localparam logic [1:0]  ASTI_MIN_SCK    = 2'h2;    // least gap in sck periods

  // processor memory access
  typedef struct packed {
    logic        wr_byte;  // full byte write
    logic        wr_bit;   // single bit write
    logic        rd;       // read strobe
    logic [15:0] addr;     // memory address
    logic [7:0]  wdata;    // byte write data
    logic [2:0]  bit_sel;  // bit index for bit write
    logic        bit_val;  // bit value for bit write
  } asti_cpu_req_t;

  // link to the transfer logic
  typedef struct packed {
    logic byte_done;       // one byte transfer ended
    logic sck_tick;        // one pulse per serial clock period
    logic active;          // automatic transfer in progress
  } asti_xfer_t;
endpackage

// File: verification/test_auto_serial_transfer_interval.sv
`timescale 1ns/100ps
module test_auto_serial_transfer_interval;
  localparam logic [15:0]  REG = asti_pkg::ASTI_REG_ADDR; // interval register
  logic                    clock;                  // main clock
  logic                    sys_rst;                // sync reset
  asti_pkg::asti_cpu_req_t cpu_req;                // processor access
  logic                    osc_div2_sel;           // halved timebase
  asti_pkg::asti_xfer_t    xfer;                   // transfer link
  logic [7:0]              cpu_rdata;              // read data
  logic                    hold_sck;               // gap running
  logic                    busy_option_disable;    // busy option off
  logic                    interval_timing_enable; // timing on
  int                      err_total;              // mismatches
  int                      comparisons;            // checks made
  int                      cycles;                 // hang guard
  logic [7:0]              tick_cnt;               // sck spacing
  logic [7:0]              sck_period;             // clocks per sck period

  asti_interval i_asti_interval (
    .clock                  (clock),
    .sys_rst                (sys_rst),
    .cpu_req                (cpu_req),
    .osc_div2_sel           (osc_div2_sel),
    .xfer                   (xfer),
    .cpu_rdata              (cpu_rdata),
    .hold_sck               (hold_sck),
    .busy_option_disable    (busy_option_disable),
    .interval_timing_enable (interval_timing_enable)
  );

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // serial period tick every sck_period clocks
  always @(posedge clock) begin
    if (tick_cnt == sck_period - 8'h01) begin
      tick_cnt <= 8'h00;
      xfer.sck_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      xfer.sck_tick <= 1'b0;
    end
  end

  // byte compare
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // gap length compare against a window
  task chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // closing report
  task results;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // byte write, one cycle strobe
  task wr(input logic [15:0] a, input logic [7:0] d);
    while (xfer.active !== 1'b0) begin
      @(posedge clock);
    end
    @(posedge clock);
    cpu_req.wr_byte <= 1'b1;
    cpu_req.addr <= a;
    cpu_req.wdata <= d;
    @(posedge clock);
    cpu_req.wr_byte <= 1'b0;
  endtask

  // bit write at the register
  task bitw(input logic [2:0] b, input logic v);
    @(posedge clock);
    cpu_req.wr_bit <= 1'b1;
    cpu_req.addr <= REG;
    cpu_req.bit_sel <= b;
    cpu_req.bit_val <= v;
    @(posedge clock);
    cpu_req.wr_bit <= 1'b0;
  endtask

  // read and compare one cycle later
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    cpu_req.rd <= 1'b1;
    cpu_req.addr <= a;
    @(posedge clock);
    cpu_req.rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
  endtask

  // one byte-end pulse
  task done_pulse;
    @(posedge clock);
    xfer.byte_done <= 1'b1;
    xfer.active <= 1'b1;
    @(posedge clock);
    xfer.byte_done <= 1'b0;
    #1;
  endtask

  // transfer done, software sees the active flag drop
  task finish_xfer;
    @(posedge clock);
    xfer.active <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // reset state of register and flags
  task t_reset;
    rd(REG, 8'h00);
    chk({hold_sck, busy_option_disable, interval_timing_enable}, 8'h00);
  endtask

  // full byte write with reserved bits set
  task t_byte;
    wr(REG, 8'hFF);
    rd(REG, 8'h9F);
    chk({busy_option_disable, interval_timing_enable}, 8'h03);
  endtask

  // single bit writes, reserved bit stays zero
  task t_bit;
    wr(REG, 8'h00);
    bitw(3'h7, 1'b1);
    bitw(3'h2, 1'b1);
    bitw(3'h5, 1'b1);
    rd(REG, 8'h84);
    bitw(3'h7, 1'b0);
    rd(REG, 8'h04);
    wr(16'hFF6A, 8'h55);
    rd(REG, 8'h04);
    rd(16'hFF6A, 8'h00);
  endtask

  // timing off: no gap after a byte
  task t_off;
    wr(REG, 8'h1F);
    done_pulse();
    repeat (20) begin
      @(posedge clock);
      #1 chk({hold_sck, busy_option_disable}, 8'h00);
    end
    finish_xfer();
  endtask

  // timed gap length for count n and timebase
  task t_gap(input logic [4:0] n, input logic div, input int p);
    int len;
    int m;
    int lo;
    int hi;
    m = div ? 2 : 1;
    lo = m * ((n + 1) * 64 + 28) + p / 2;
    hi = m * ((n + 1) * 64 + 36) + (3 * p) / 2;
    // floor of two serial periods; release waits for a tick, one period more
    if (lo < 2 * p) lo = 2 * p;
    if (hi < 3 * p) hi = 3 * p;
    wr(REG, {3'h4, n});
    osc_div2_sel <= div;
    sck_period <= p[7:0];
    done_pulse();
    chk({7'h00, hold_sck}, 8'h01);
    len = 0;
    while (hold_sck === 1'b1 && len < 5000) begin
      len++;
      @(posedge clock);
      #1;
    end
    chk_rng(len, lo, hi);
    finish_xfer();
  endtask

  // reset in the middle of a gap clears register and hold
  task t_rst_mid;
    wr(REG, 8'h85);
    done_pulse();
    repeat (3) @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk({hold_sck, busy_option_disable, interval_timing_enable}, 8'h00);
    finish_xfer();
    rd(REG, 8'h00);
  endtask

  // hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles == 20000) begin
        err_total++;
        results();
      end
    end
  end

  // main sequence
  initial begin
    err_total = 0;
    comparisons = 0;
    tick_cnt = 8'h00;
    sck_period = 8'h04;
    sys_rst = 1'b1;
    cpu_req = '0;
    xfer = '0;
    osc_div2_sel = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_byte();
    t_bit();
    t_off();
    t_gap(5'h00, 1'b0, 4);
    t_gap(5'h01, 1'b1, 4);
    t_gap(5'h1F, 1'b0, 4);
    t_gap(5'h00, 1'b0, 200);
    t_rst_mid();
    results();
  end
endmodule // test_auto_serial_transfer_interval
